/* File: tzta_pkg.sv */
/*
 Package for the three-zone thermal alarm logic: power-up values,
 configuration field positions, filter depth encodings, zone indices.
 Assumes nothing of its surroundings.
*/
package tzta_pkg;
    // ------------------------------------------------------------
    // Configuration field positions
    // ------------------------------------------------------------
    localparam int CFG_SHUTDOWN_BIT_POS = 0;   // Shutdown bit
    localparam int CFG_MODE_POS = 1;   // Comparator (0) / interrupt (1)
    localparam int CFG_MASK_POS = 2;   // Alert mask
    localparam int CFG_FQ_LO = 3;      // Filter depth low bit
    localparam int CFG_FQ_HI = 4;      // Filter depth high bit
    localparam logic [4:0] CFG_RESET = 5'h00; // Control power-up value

    // ------------------------------------------------------------
    // Power-up limits, two's complement whole degrees
    // ------------------------------------------------------------
    localparam logic [7:0] LOCAL_HIGH_RST = 8'h51;  // +81 C
    localparam logic [7:0] LOCAL_LOW_RST = 8'h4C;   // +76 C
    localparam logic [7:0] REMOTE_HIGH_RST = 8'h61; // +97 C
    localparam logic [7:0] REMOTE_LOW_RST = 8'h5C;  // +92 C
    localparam logic [7:0] FULL_SCALE = 8'h7F;      // Faulted sense reading

    // ------------------------------------------------------------
    // Filter depth encodings and counts
    // ------------------------------------------------------------
    localparam logic [1:0] FQ_ONE = 2'h0;
    localparam logic [1:0] FQ_TWO = 2'h1;
    localparam logic [1:0] FQ_FOUR = 2'h2;
    localparam logic [1:0] FQ_SIX = 2'h3;
    localparam logic [2:0] DEPTH_ONE = 3'h1;
    localparam logic [2:0] DEPTH_TWO = 3'h2;
    localparam logic [2:0] DEPTH_FOUR = 3'h4;
    localparam logic [2:0] DEPTH_SIX = 3'h6;

    // ------------------------------------------------------------
    // Zones
    // ------------------------------------------------------------
    localparam int NZONE = 3;
    localparam int ZONE_LOCAL = 0;
    localparam int ZONE_R1 = 1;
    localparam int ZONE_R2 = 2;
endpackage

/* File: tzta_limit_mem.sv */
/*
 Limit store: high and low limit per zone, written by the host and
 read back through a register. Assumes one synchronous clock/reset.
*/
`timescale 1ns/10ps
module tzta_limit_mem (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [1:0] wr_zone,
    input wire logic wr_high,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_zone,
    input wire logic rd_high,
    output logic [7:0] rd_data_r,
    output logic [23:0] high_all,
    output logic [23:0] low_all
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0][7:0] high; // Upper limits
        logic [2:0][7:0] low;  // Lower limits
        logic [7:0] rd;        // Registered read data
    } tzta_mem_t;
    tzta_mem_t st_r, st_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (wr_en && wr_zone < 2'h3) begin
            if (wr_high) begin
                st_nxt.high[wr_zone] = wr_data;
            end else begin
                st_nxt.low[wr_zone] = wr_data;
            end
        end
        // Out-of-range zone reads as zero
        if (rd_zone < 2'h3) begin
            st_nxt.rd = rd_high ? st_r.high[rd_zone] : st_r.low[rd_zone];
        end else begin
            st_nxt.rd = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r.high <= {tzta_pkg::REMOTE_HIGH_RST, tzta_pkg::REMOTE_HIGH_RST, tzta_pkg::LOCAL_HIGH_RST};
            st_r.low <= {tzta_pkg::REMOTE_LOW_RST, tzta_pkg::REMOTE_LOW_RST, tzta_pkg::LOCAL_LOW_RST};
            st_r.rd <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_r = st_r.rd;
    assign high_all = st_r.high;
    assign low_all = st_r.low;
endmodule

/* File: tzta_alarm.sv */
/*
 Three-zone thermal alarm logic: per-zone limit compare, consecutive
 count filter, sticky flags, alert and overheat outputs.
 Assumes conversion results arrive with a one-cycle strobe and zone
 index, host accesses arrive as one-cycle strobes, all on mclk.
*/
// Operation
// - Power-up: running, comparator, depth one, unmasked
// - Power-up limits 81/76 local, 97/92 remote
// - Address select sampled once after reset
// - Comparator: alert on filtered over-limit
// - Comparator: release after filtered under-low
// - Comparator: shutdown keeps alert level
// - Interrupt: release on read or shutdown
// - Interrupt: re-arm needs opposite crossing
// - Armed for over-limit first
// - Shutdown stops conversions, registers stay accessible
// - Interrupt-mode shutdown clears alert and flags
// - No events while shut down
// - Depth field: 1, 2, 4, 6
// - Independent per-zone consecutive filters
// - Flags unmasked; alert needs mask zero
// - Control read, comparator release and interrupt-mode shutdown clear flags
// - Interrupt-mode flags sticky, repeats merge
// - Zone events map to flags 0..2
// - Sense fault sets flag, alert, overheat
// - Values are signed whole degrees
// - Mask one disables alert drive
`timescale 1ns/10ps
module tzta_alarm #(
    parameter int ZW = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic addr_select_pin,
    input wire logic conv_valid,
    input wire logic [1:0] conv_zone,
    input wire logic [ZW-1:0] zone_temp_result,
    input wire logic remote_sense_one,
    input wire logic remote_sense_two,
    input wire logic cfg_wr,
    input wire logic [4:0] cfg_wdata,
    input wire logic lim_wr,
    input wire logic [1:0] lim_zone,
    input wire logic lim_high,
    input wire logic [7:0] lim_wdata,
    input wire logic [1:0] lim_rd_zone,
    input wire logic lim_rd_high,
    input wire logic reg_rd,
    input wire logic cfg_rd,
    output logic [7:0] lim_rdata,
    output logic [2:0] zone_flags,
    output logic [4:0] cfg_out,
    output logic [23:0] zone_temps,
    output logic alert_out,
    output logic alert_oe_n,
    output logic overheat_out,
    output logic overheat_oe_n,
    output logic remote_overheat_flag,
    output logic bus_addr_lsb,
    output logic converting
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic shutdown_bit;               // Shutdown bit
        logic mode;               // 1 = interrupt mode
        logic mask;               // Alert mask bit
        logic [1:0] fq;           // Filter depth field
        logic [2:0] flag;         // Sticky zone flags
        logic [2:0] under_armed;  // 1 = waiting for under-low
        logic [2:0][2:0] cnt;     // Per-zone consecutive count
        logic [2:0][7:0] temp;    // Latest results
        logic alert;              // Alert asserted
        logic overheat_out_n;               // Overheat asserted
        logic addr_done;          // Address captured
        logic addr;               // Captured address bit
        logic alert_oe_n;         // Alert pin enable, low sinks
        logic overheat_out_n_oe_n;          // Overheat pin enable, low sinks
        logic run;                // Conversions running
    } tzta_st_t;
    tzta_st_t st_r, st_nxt;

    logic [23:0] high_all; // Upper limits from store
    logic [23:0] low_all;  // Lower limits from store
    logic [2:0] depth;     // Decoded depth count

    // ------------------------------------------------------------
    // Limit store
    // ------------------------------------------------------------
    tzta_limit_mem u_mem (
        .mclk(mclk),
        .rst(rst),
        .wr_en(lim_wr),
        .wr_zone(lim_zone),
        .wr_high(lim_high),
        .wr_data(lim_wdata),
        .rd_zone(lim_rd_zone),
        .rd_high(lim_rd_high),
        .rd_data_r(lim_rdata),
        .high_all(high_all),
        .low_all(low_all)
    );

    // ------------------------------------------------------------
    // Depth decode
    // ------------------------------------------------------------
    always_comb begin
        case (st_r.fq)
            tzta_pkg::FQ_ONE: depth = tzta_pkg::DEPTH_ONE;
            tzta_pkg::FQ_TWO: depth = tzta_pkg::DEPTH_TWO;
            tzta_pkg::FQ_FOUR: depth = tzta_pkg::DEPTH_FOUR;
            tzta_pkg::FQ_SIX: depth = tzta_pkg::DEPTH_SIX;
            default: depth = tzta_pkg::DEPTH_ONE;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] t;       // Effective result
        logic [7:0] hi;      // Zone upper limit
        logic [7:0] lo;      // Zone lower limit
        logic cond;          // Pending condition met
        logic fault;         // Sense line fault
        logic qual;          // Qualified event
        logic z;             // Zone index valid
        logic entering;      // Shutdown rising
        int zi;
        t = 8'h00;
        hi = 8'h00;
        lo = 8'h00;
        cond = 1'b0;
        fault = 1'b0;
        qual = 1'b0;
        z = 1'b0;
        entering = 1'b0;
        zi = 0;
        st_nxt = st_r;

        if (!st_r.addr_done) begin
            st_nxt.addr = addr_select_pin;
            st_nxt.addr_done = 1'b1;
        end

        // control writes work in any state
        if (cfg_wr) begin
            st_nxt.shutdown_bit = cfg_wdata[tzta_pkg::CFG_SHUTDOWN_BIT_POS];
            st_nxt.mode = cfg_wdata[tzta_pkg::CFG_MODE_POS];
            st_nxt.mask = cfg_wdata[tzta_pkg::CFG_MASK_POS];
            st_nxt.fq = cfg_wdata[tzta_pkg::CFG_FQ_HI:tzta_pkg::CFG_FQ_LO];
            entering = cfg_wdata[tzta_pkg::CFG_SHUTDOWN_BIT_POS] && !st_r.shutdown_bit;
        end

        if (cfg_rd) begin
            st_nxt.flag = 3'h0;
        end
        // any read releases alert in interrupt mode
        if (reg_rd && st_r.mode) begin
            st_nxt.alert = 1'b0;
        end

        z = conv_valid && !st_r.shutdown_bit && conv_zone < 2'h3;
        if (z) begin
            zi = int'(conv_zone);
            hi = high_all[zi*8 +: 8];
            lo = low_all[zi*8 +: 8];
            fault = (zi == tzta_pkg::ZONE_R1 && remote_sense_one) ||
                    (zi == tzta_pkg::ZONE_R2 && remote_sense_two);
            t = fault ? tzta_pkg::FULL_SCALE : zone_temp_result[7:0];
            st_nxt.temp[zi] = t;
            cond = st_r.under_armed[zi] ? ($signed(t) < $signed(lo)) : ($signed(t) > $signed(hi));
            if (!cond) begin
                st_nxt.cnt[zi] = 3'h0;
            end else if (st_r.cnt[zi] + 3'h1 >= depth) begin
                qual = 1'b1;
                st_nxt.cnt[zi] = 3'h0;
            end else begin
                st_nxt.cnt[zi] = st_r.cnt[zi] + 3'h1;
            end
            if (qual) begin
                st_nxt.under_armed[zi] = !st_r.under_armed[zi];
                if (!st_r.mode) begin
                    st_nxt.flag[zi] = !st_r.under_armed[zi];
                    st_nxt.alert = 1'b0;
                end else begin
                    st_nxt.flag[zi] = 1'b1;
                    st_nxt.alert = 1'b1;
                end
                if (fault && !st_r.under_armed[zi]) begin
                    st_nxt.overheat_out_n = 1'b1;
                end else if (zi != tzta_pkg::ZONE_LOCAL) begin
                    st_nxt.overheat_out_n = 1'b0;
                end
            end
        end
        // Comparator alert is the OR of zone states
        if (!st_r.mode) begin
            st_nxt.alert = |st_nxt.flag;
        end

        if (entering && st_r.mode) begin
            st_nxt.alert = 1'b0;
            st_nxt.flag = 3'h0;
            st_nxt.overheat_out_n = 1'b0;
            st_nxt.under_armed = 3'h0;
        end

        st_nxt.alert_oe_n = !(st_nxt.alert && !st_nxt.mask);
        st_nxt.overheat_out_n_oe_n = !st_nxt.overheat_out_n;
        st_nxt.run = !st_nxt.shutdown_bit;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r.shutdown_bit <= tzta_pkg::CFG_RESET[tzta_pkg::CFG_SHUTDOWN_BIT_POS];
            st_r.mode <= tzta_pkg::CFG_RESET[tzta_pkg::CFG_MODE_POS];
            st_r.mask <= tzta_pkg::CFG_RESET[tzta_pkg::CFG_MASK_POS];
            st_r.fq <= tzta_pkg::CFG_RESET[tzta_pkg::CFG_FQ_HI:tzta_pkg::CFG_FQ_LO];
            st_r.flag <= 3'h0;
            st_r.under_armed <= 3'h0;
            st_r.cnt <= '0;
            st_r.temp <= '0;
            st_r.alert <= 1'b0;
            st_r.overheat_out_n <= 1'b0;
            st_r.addr_done <= 1'b0;
            st_r.addr <= 1'b0;
            st_r.alert_oe_n <= 1'b1;
            st_r.overheat_out_n_oe_n <= 1'b1;
            st_r.run <= !tzta_pkg::CFG_RESET[tzta_pkg::CFG_SHUTDOWN_BIT_POS];
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs; alert pin sinks only when alert and unmasked, overheat pin on overheat
    // ------------------------------------------------------------
    // Open-drain data is always low, the enable carries the level
    assign alert_out = 1'b0;
    assign alert_oe_n = st_r.alert_oe_n;
    assign overheat_out = 1'b0;
    assign overheat_oe_n = st_r.overheat_out_n_oe_n;
    assign zone_flags = st_r.flag;
    assign cfg_out = {st_r.fq, st_r.mask, st_r.mode, st_r.shutdown_bit};
    assign zone_temps = st_r.temp;
    assign remote_overheat_flag = st_r.overheat_out_n;
    assign bus_addr_lsb = st_r.addr;
    assign converting = st_r.run;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_enter_int;
        cfg_wr && cfg_wdata[0] && !st_r.shutdown_bit && st_r.mode;
    endsequence
    property p_int_shutdown_bit;
        @(posedge mclk) disable iff (rst) s_enter_int |=> (zone_flags == 3'h0) ##1 alert_oe_n;
    endproperty
    a_int_shutdown_bit: assert property (p_int_shutdown_bit) else $error("shutdown kept interrupt state");
    property p_mask;
        @(posedge mclk) disable iff (rst) st_r.mask |-> alert_oe_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked alert drove pin");
    property p_cfg_clear;
        @(posedge mclk) disable iff (rst) (cfg_rd && !conv_valid) |=> zone_flags == 3'h0;
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("control read left flags");
    property p_sticky;
        @(posedge mclk) disable iff (rst) (st_r.mode && |zone_flags && !cfg_rd && !cfg_wr) |=> |zone_flags;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without read");
    property p_shutdown_bit_quiet;
        @(posedge mclk) disable iff (rst) (st_r.shutdown_bit && !cfg_wr && !cfg_rd) |=> $stable(zone_flags);
    endproperty
    a_shutdown_bit_quiet: assert property (p_shutdown_bit_quiet) else $error("event while shut down");
    property p_read_rel;
        @(posedge mclk) disable iff (rst) (reg_rd && st_r.mode && !conv_valid) |=> alert_oe_n;
    endproperty
    a_read_rel: assert property (p_read_rel) else $error("read did not release alert");
    property p_cmp_alert;
        @(posedge mclk) disable iff (rst)
            (!st_r.mode && !st_r.mask && |zone_flags && !cfg_wr && !cfg_rd && !conv_valid) |=> !alert_oe_n;
    endproperty
    a_cmp_alert: assert property (p_cmp_alert) else $error("comparator alert missing");
    property p_addr;
        @(posedge mclk) disable iff (rst) st_r.addr_done |=> $stable(bus_addr_lsb);
    endproperty
    a_addr: assert property (p_addr) else $error("address changed after capture");
endmodule

/* File: tzta_host_model.sv */
/*
 Host controller model for the thermal alarm block: strobe-level
 register writes and reads, plus pull-ups on the two open-drain pins.
 Assumes every strobe is sampled on the rising edge of mclk and that
 the bench calls these tasks from one process only.
*/
`timescale 1ns/10ps
module tzta_host_model (
    input wire logic mclk,
    output logic cfg_wr,
    output logic [4:0] cfg_wdata,
    output logic lim_wr,
    output logic [1:0] lim_zone,
    output logic lim_high,
    output logic [7:0] lim_wdata,
    output logic [1:0] lim_rd_zone,
    output logic lim_rd_high,
    output logic reg_rd,
    output logic cfg_rd,
    input wire logic [7:0] lim_rdata,
    input wire logic [4:0] cfg_out,
    input wire logic [2:0] zone_flags,
    input wire logic alert_out,
    input wire logic alert_oe_n,
    input wire logic overheat_out,
    input wire logic overheat_oe_n,
    output logic alert_line,
    output logic overheat_line
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Pull-up wins whenever the device releases its pin
    assign alert_line = alert_oe_n ? 1'b1 : alert_out;
    assign overheat_line = overheat_oe_n ? 1'b1 : overheat_out;

    // Idle strobes from time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_wdata = 5'h00;
        lim_wr = 1'b0;
        lim_zone = 2'h0;
        lim_high = 1'b0;
        lim_wdata = 8'h00;
        lim_rd_zone = 2'h0;
        lim_rd_high = 1'b0;
        reg_rd = 1'b0;
        cfg_rd = 1'b0;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // Polling host masks alert
    // Control write; a polling host passes a value with the mask set
    task automatic cfg_write(input logic [4:0] v);
        @(negedge mclk);
        cfg_wdata = v;
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
    endtask

    // Limit write, one byte
    task automatic lim_write(input logic [1:0] z, input logic h, input logic [7:0] v);
        @(negedge mclk);
        lim_zone = z;
        lim_high = h;
        lim_wdata = v;
        lim_wr = 1'b1;
        @(negedge mclk);
        lim_wr = 1'b0;
    endtask

    // Limit read; data is registered, so it is taken one cycle later
    task automatic lim_read(input logic [1:0] z, input logic h, output logic [7:0] v);
        @(negedge mclk);
        lim_rd_zone = z;
        lim_rd_high = h;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        v = lim_rdata;
    endtask

    // Host confirms source first
    // Control read: flags are captured before the clearing edge
    task automatic cfg_read(output logic [7:0] v);
        @(negedge mclk);
        v = {zone_flags, cfg_out};
        reg_rd = 1'b1;
        cfg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        cfg_rd = 1'b0;
    endtask
endmodule

/* File: test_tzta_alarm.sv */
/*
 Self-checking bench for the three-zone thermal alarm logic.
 Assumes the host model drives all register strobes and the bench
 drives conversions and sense faults on the falling edge of mclk.
*/
`timescale 1ns/10ps
module test_tzta_alarm;
    logic mclk = 1'b0; // 40 MHz
    logic rst = 1'b1;
    logic addr_select_pin = 1'b1;
    logic conv_valid = 1'b0;
    logic [1:0] conv_zone = 2'h0;
    logic [7:0] zone_temp_result = 8'h00;
    logic remote_sense_one = 1'b0;
    logic remote_sense_two = 1'b0;
    logic cfg_wr, lim_wr, lim_high, lim_rd_high, reg_rd, cfg_rd;
    logic [4:0] cfg_wdata, cfg_out;
    logic [1:0] lim_zone, lim_rd_zone;
    logic [7:0] lim_wdata, lim_rdata, rv;
    logic [2:0] zone_flags;
    logic [23:0] zone_temps;
    logic alert_out, alert_oe_n, overheat_out, overheat_oe_n;
    logic remote_overheat_flag, bus_addr_lsb, converting;
    logic alert_line, overheat_line;
    int bad_count = 0;
    int compares = 0;
    logic [2:0] depths [4] = '{3'h1, 3'h2, 3'h4, 3'h6}; // Depth per code

    always #12.5 mclk = ~mclk;

    tzta_alarm uut (.mclk(mclk), .rst(rst), .addr_select_pin(addr_select_pin), .conv_valid(conv_valid),
        .conv_zone(conv_zone), .zone_temp_result(zone_temp_result), .remote_sense_one(remote_sense_one),
        .remote_sense_two(remote_sense_two), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .lim_wr(lim_wr),
        .lim_zone(lim_zone), .lim_high(lim_high), .lim_wdata(lim_wdata), .lim_rd_zone(lim_rd_zone),
        .lim_rd_high(lim_rd_high), .reg_rd(reg_rd), .cfg_rd(cfg_rd), .lim_rdata(lim_rdata),
        .zone_flags(zone_flags), .cfg_out(cfg_out), .zone_temps(zone_temps), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .overheat_out(overheat_out), .overheat_oe_n(overheat_oe_n),
        .remote_overheat_flag(remote_overheat_flag), .bus_addr_lsb(bus_addr_lsb), .converting(converting));

    tzta_host_model host (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .lim_wr(lim_wr),
        .lim_zone(lim_zone), .lim_high(lim_high), .lim_wdata(lim_wdata), .lim_rd_zone(lim_rd_zone),
        .lim_rd_high(lim_rd_high), .reg_rd(reg_rd), .cfg_rd(cfg_rd), .lim_rdata(lim_rdata),
        .cfg_out(cfg_out), .zone_flags(zone_flags), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .overheat_out(overheat_out), .overheat_oe_n(overheat_oe_n), .alert_line(alert_line),
        .overheat_line(overheat_line));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare and count; values widened to 24 bits
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // n conversions, one idle cycle between, results settle by the next fall
    task automatic conv(input logic [1:0] z, input logic [7:0] t, input int n);
        repeat (n) begin
            @(negedge mclk);
            conv_zone = z;
            zone_temp_result = t;
            conv_valid = 1'b1;
            @(negedge mclk);
            conv_valid = 1'b0;
        end
    endtask

    // Single exit point of the run
    task automatic give_verdict;
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles of the sequence
    initial begin
        #(25 * 20000);
        bad_count++;
        give_verdict;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        addr_select_pin = 1'b0; // Late change must not move the address
        check("cfg", cfg_out, 24'h0);
        check("flags", zone_flags, 24'h0);
        check("alert", alert_line, 24'h1);
        check("converting", converting, 24'h1);
        check("addr", bus_addr_lsb, 24'h1);
        host.lim_read(2'h0, 1'b1, rv); check("lim0h", rv, 24'h51);
        host.lim_read(2'h0, 1'b0, rv); check("lim0l", rv, 24'h4C);
        for (int z = 1; z < 3; z++) begin
            host.lim_read(z[1:0], 1'b1, rv); check("limrh", rv, 24'h61);
            host.lim_read(z[1:0], 1'b0, rv); check("limrl", rv, 24'h5C);
        end
        // Comparator follow and release, local zone
        conv(2'h0, 8'h52, 1);
        check("temps0", zone_temps[7:0], 24'h52);
        check("flags", zone_flags, 24'h1);
        check("alert", alert_line, 24'h0);
        conv(2'h0, 8'h4D, 1); check("alert", alert_line, 24'h0);
        conv(2'h0, 8'h4B, 1); check("alert", alert_line, 24'h1);
        check("flags", zone_flags, 24'h0);
        // Every depth code, zone 1 with zone 2 traffic between
        for (int i = 0; i < 4; i++) begin
            host.cfg_write({i[1:0], 3'h0});
            for (int k = 1; k < depths[i]; k++) begin
                conv(2'h1, 8'h62, 1);
                conv(2'h2, 8'h5D, 1);
            end
            conv(2'h1, 8'h5D, 1);
            conv(2'h1, 8'h62, depths[i] - 1);
            check("flags", zone_flags, 24'h0);
            conv(2'h1, 8'h62, 1);
            check("flags", zone_flags, 24'h2);
            conv(2'h1, 8'h5B, depths[i] - 1);
            check("flags", zone_flags, 24'h2);
            conv(2'h1, 8'h5B, 1);
            check("flags", zone_flags, 24'h0);
        end
        // Masked alert still sets the flag
        host.cfg_write(5'h04);
        conv(2'h2, 8'h62, 1);
        check("flags", zone_flags, 24'h4);
        check("alert", alert_line, 24'h1);
        conv(2'h2, 8'h5B, 1);
        // Interrupt mode latching and re-arm
        host.cfg_write(5'h02);
        conv(2'h0, 8'h52, 2);
        check("alert", alert_line, 24'h0);
        host.lim_read(2'h0, 1'b1, rv);
        check("alert", alert_line, 24'h1);
        check("flags", zone_flags, 24'h1);
        conv(2'h0, 8'h52, 1); check("alert", alert_line, 24'h1);
        conv(2'h0, 8'h4B, 1); check("alert", alert_line, 24'h0);
        host.cfg_read(rv); check("cfgrd", rv, 24'h22);
        check("flags", zone_flags, 24'h0);
        check("alert", alert_line, 24'h1);
        conv(2'h0, 8'h4B, 1); check("flags", zone_flags, 24'h0);
        conv(2'h0, 8'h52, 1); check("alert", alert_line, 24'h0);
        // Interrupt-mode shutdown clears alert and flags, stops conversions
        host.cfg_write(5'h03);
        check("alert", alert_line, 24'h1);
        check("flags", zone_flags, 24'h0);
        check("converting", converting, 24'h0);
        conv(2'h1, 8'h62, 1); check("flags", zone_flags, 24'h0);
        host.lim_write(2'h1, 1'b1, 8'h70);
        host.lim_read(2'h1, 1'b1, rv); check("lim1h", rv, 24'h70);
        host.lim_write(2'h1, 1'b1, 8'h61);
        // Comparator-mode shutdown keeps the pin
        host.cfg_write(5'h00);
        conv(2'h0, 8'h52, 1);
        host.cfg_write(5'h01);
        check("alert", alert_line, 24'h0);
        conv(2'h0, 8'h4B, 1); check("alert", alert_line, 24'h0);
        host.cfg_write(5'h00);
        conv(2'h0, 8'h4B, 1); check("alert", alert_line, 24'h1);
        // Remote sense fault
        remote_sense_one = 1'b1;
        conv(2'h1, 8'h00, 1);
        check("temps1", zone_temps[15:8], 24'h7F);
        check("flags", zone_flags, 24'h2);
        check("alert", alert_line, 24'h0);
        check("overheat", overheat_line, 24'h0);
        check("ovflag", remote_overheat_flag, 24'h1);
        remote_sense_one = 1'b0;
        conv(2'h1, 8'h5B, 1);
        check("overheat", overheat_line, 24'h1);
        check("flags", zone_flags, 24'h0);
        // Remote sense fault, second zone
        remote_sense_two = 1'b1;
        conv(2'h2, 8'h00, 1); check("temps2", zone_temps[23:16], 24'h7F);
        check("flags", zone_flags, 24'h4);
        check("overheat", overheat_line, 24'h0);
        remote_sense_two = 1'b0;
        conv(2'h2, 8'h5B, 1); check("ovflag", remote_overheat_flag, 24'h0);
        check("flags", zone_flags, 24'h0);
        // Signed compare around zero
        host.lim_write(2'h0, 1'b1, 8'h00);
        conv(2'h0, 8'hFF, 1); check("flags", zone_flags, 24'h0);
        conv(2'h0, 8'h01, 1); check("flags", zone_flags, 24'h1);
        give_verdict;
    end
endmodule
